// File: logic/rgdec_pkg.sv
`default_nettype none

package rgdec_pkg;

   // ************************************************************
   // geometry of a block and of one channel word
   // ************************************************************
   localparam int unsigned BYTE_W       = 8;
   localparam int unsigned WORD_BYTES   = 8;
   localparam int unsigned WORD_W       = 64;
   localparam int unsigned BLOCK_W      = 128;
   localparam int unsigned TEXELS       = 16;
   localparam int unsigned TEXEL_SEL_W  = 4;
   localparam int unsigned IDX_W        = 3;
   localparam int unsigned TABLES       = 16;
   localparam int unsigned TAB_ENTRIES  = 8;
   localparam int unsigned MOD_W        = 8;
   localparam int unsigned ROM_W        = TABLES * TAB_ENTRIES * MOD_W;

   // ************************************************************
   // field positions inside a channel word
   // ************************************************************
   localparam int unsigned BASE_MSB     = 63;
   localparam int unsigned BASE_LSB     = 56;
   localparam int unsigned MULT_MSB     = 55;
   localparam int unsigned MULT_LSB     = 52;
   localparam int unsigned TSEL_MSB     = 51;
   localparam int unsigned TSEL_LSB     = 48;
   localparam int unsigned IDX_TOP      = 47;

   // ************************************************************
   // arithmetic widths, terms and limits
   // ************************************************************
   localparam int unsigned RES_W        = 11;
   localparam int unsigned WIDE_W       = 16;
   localparam int unsigned SUM_W        = 18;
   localparam int unsigned SCALE_SH     = 3;
   localparam int unsigned WIDEN_SH_L   = 5;
   localparam int unsigned U_WIDEN_SH_R = 6;
   localparam int unsigned S_WIDEN_SH_R = 5;
   localparam logic signed [SUM_W-1:0] ROUND_TERM = 18'sh00004;
   localparam logic signed [SUM_W-1:0] U_MIN      = 18'sh00000;
   localparam logic signed [SUM_W-1:0] U_MAX      = 18'sh007FF;
   localparam logic signed [SUM_W-1:0] S_MIN      = -18'sh003FF;
   localparam logic signed [SUM_W-1:0] S_MAX      = 18'sh003FF;
   localparam logic [BYTE_W-1:0]       BASE_NEG_BAD  = 8'h80;
   localparam logic [BYTE_W-1:0]       BASE_NEG_SUBST = 8'h81;

   // table 13, leftmost entry in the top byte
   localparam logic [TAB_ENTRIES*MOD_W-1:0] TABLE13 =
      {8'hFF, 8'hFE, 8'hFD, 8'hF6, 8'h00, 8'h01, 8'h02, 8'h09};

   // ************************************************************
   // formats and carriers
   // ************************************************************
   typedef enum logic [2:0] {
      RGDEC_SINGLE_CHANNEL_UNSIGNED_FORMAT = 3'b001,
      RGDEC_DUAL_CHANNEL_UNSIGNED_FORMAT   = 3'b010,
      RGDEC_SINGLE_CHANNEL_SIGNED_FORMAT   = 3'b100
   } rgdec_fmt_t;

   typedef struct packed {
      logic [RES_W-1:0]  v11;
      logic [WIDE_W-1:0] v16;
   } rgdec_texel_t;

   typedef struct packed {
      logic         valid;
      rgdec_fmt_t   fmt;
      rgdec_texel_t red;
      rgdec_texel_t green;
   } rgdec_state_t;

endpackage : rgdec_pkg

`default_nettype wire

// File: logic/rgdec_decoder.sv
`default_nettype none

// Summary of operation
// (RULE1) dual unsigned format takes 16 bytes; first eight and last eight form two words
// (RULE2) lowest-addressed byte is most significant; first word red, second green
// (RULE3) red and green words decode independently by the same unsigned procedure
// (RULE4) unsigned: base*8 + 4 + modifier*multiplier*8, clamped 0..2047
// (RULE5) unsigned widening to 16 bits: (x<<5) + (x>>6)
// (RULE6) signed format takes 8 bytes, lowest byte most significant, red channel
// (RULE7) base value is the top 8 bits of the word
// (RULE8) signed base is two's complement; -128 is used as -127
// (RULE9) bits 51..48 pick one of sixteen tables of eight signed entries
// (RULE10) bits 47..0 hold sixteen 3-bit texel indices; texel 1 at 44..42
// (RULE11) index counts from leftmost entry; table 13 is -1,-2,-3,-10,0,1,2,9
// (RULE12) multiplier in bits 55..52; nonzero multiplies modifier, product shifted left 3
// (RULE13) signed: base*8 plus scaled product, saturated to -1023..1023
// (RULE14) zero multiplier adds the unscaled modifier instead
// (RULE15) signed result is 11-bit two's complement, +-1023 meaning +-1
// (RULE16) non-negative signed widening: (x<<5) + (x>>5), sign not replicated
// (RULE17) negative signed widening: negate, widen, negate again
// (RULE18) wider outputs use the same replication; never fewer than 11 bits
// (RULE19) one datapath; mode picks only +4 term, clamp range and widening; here mode also picks the base sign extension
// (RULE20) all sixteen modifier tables sit in a constant lookup rom; the default MOD_ROM holds table 13 sixteen times
// (RULE21) texel slots run from the top down; texel 0 at bits 47..45

module rgdec_decoder #(
   parameter logic [rgdec_pkg::ROM_W-1:0] MOD_ROM = {rgdec_pkg::TABLES{rgdec_pkg::TABLE13}}
) (
   input  wire logic                                 clk_i,
   input  wire logic                                 rst_n_i,
   input  wire logic                                 en_i,
   input  wire logic                                 blk_valid_i,
   input  wire logic [rgdec_pkg::BLOCK_W-1:0]        blk_data_i,
   input  wire rgdec_pkg::rgdec_fmt_t                fmt_i,
   input  wire logic [rgdec_pkg::TEXEL_SEL_W-1:0]    texel_i,
   output logic                                      valid_o,
   output rgdec_pkg::rgdec_fmt_t                     fmt_o,
   output rgdec_pkg::rgdec_texel_t                   red_o,
   output rgdec_pkg::rgdec_texel_t                   green_o
);

   // ************************************************************
   // modifier lookup
   // ************************************************************

   // table t entry e sits at slot t*8+e counted from the top byte
   function automatic logic signed [rgdec_pkg::MOD_W-1:0] modifier_of(
      input logic [rgdec_pkg::TEXEL_SEL_W-1:0] tsel,
      input logic [rgdec_pkg::IDX_W-1:0]       idx
   );
      int unsigned slot;
      begin
         slot = (rgdec_pkg::TABLES * rgdec_pkg::TAB_ENTRIES - 1)
              - (int'(tsel) * rgdec_pkg::TAB_ENTRIES + int'(idx));
         modifier_of = $signed(MOD_ROM[slot*rgdec_pkg::MOD_W +: rgdec_pkg::MOD_W]); // RULE20 RULE11
      end
   endfunction : modifier_of

   // ************************************************************
   // one texel of one channel word
   // ************************************************************

   // shared by both signedness modes; sgn steers only the base sign extension and the -128 substitution, the +4
   // and the clamp, so one adder and one multiplier serve every format
   function automatic logic [rgdec_pkg::RES_W-1:0] decode_texel(
      input logic [rgdec_pkg::WORD_W-1:0]      word,
      input logic [rgdec_pkg::TEXEL_SEL_W-1:0] texel,
      input logic                              sgn
   );
      logic [rgdec_pkg::BYTE_W-1:0]           base_raw;
      logic [rgdec_pkg::MULT_MSB-rgdec_pkg::MULT_LSB:0] mult;
      logic [rgdec_pkg::TSEL_MSB-rgdec_pkg::TSEL_LSB:0] tsel;
      logic [rgdec_pkg::IDX_W-1:0]            idx;
      logic signed [rgdec_pkg::MOD_W-1:0]     modv;
      logic signed [rgdec_pkg::SUM_W-1:0]     base_t;
      logic signed [rgdec_pkg::SUM_W-1:0]     mod_t;
      logic signed [rgdec_pkg::SUM_W-1:0]     term;
      logic signed [rgdec_pkg::SUM_W-1:0]     sum;
      logic signed [rgdec_pkg::SUM_W-1:0]     lo;
      logic signed [rgdec_pkg::SUM_W-1:0]     hi;
      begin
         base_raw = word[rgdec_pkg::BASE_MSB:rgdec_pkg::BASE_LSB]; // RULE7
         mult     = word[rgdec_pkg::MULT_MSB:rgdec_pkg::MULT_LSB]; // RULE12
         tsel     = word[rgdec_pkg::TSEL_MSB:rgdec_pkg::TSEL_LSB]; // RULE9
         // texel 0 owns the top slot, each following texel the next one down
         idx      = word[rgdec_pkg::IDX_TOP - rgdec_pkg::IDX_W*int'(texel) -: rgdec_pkg::IDX_W]; // RULE10 RULE21
         modv     = modifier_of(tsel, idx);

         // base: unsigned or two's complement, times eight
         if (sgn)
         begin
            if (base_raw == rgdec_pkg::BASE_NEG_BAD)
            begin
               base_raw = rgdec_pkg::BASE_NEG_SUBST; // RULE8
            end
            base_t = $signed({{(rgdec_pkg::SUM_W-rgdec_pkg::BYTE_W){base_raw[rgdec_pkg::BYTE_W-1]}},
                              base_raw}); // RULE8
         end
         else
         begin
            base_t = $signed({{(rgdec_pkg::SUM_W-rgdec_pkg::BYTE_W){1'b0}}, base_raw});
         end
         base_t = base_t <<< rgdec_pkg::SCALE_SH; // RULE4 RULE13

         // the rounding half only exists in the unsigned format
         if (!sgn)
         begin
            base_t = base_t + rgdec_pkg::ROUND_TERM; // RULE4 RULE19
         end

         // modifier term: scaled product, or the bare modifier at zero multiplier
         mod_t = $signed({{(rgdec_pkg::SUM_W-rgdec_pkg::MOD_W){modv[rgdec_pkg::MOD_W-1]}}, modv});
         if (mult == '0)
         begin
            term = mod_t; // RULE14 RULE4
         end
         else
         begin
            term = (mod_t * $signed({{(rgdec_pkg::SUM_W-$bits(mult)){1'b0}}, mult}))
                   <<< rgdec_pkg::SCALE_SH; // RULE12
         end
         sum = base_t + term; // RULE13

         // clamp range follows the mode
         lo = sgn ? rgdec_pkg::S_MIN : rgdec_pkg::U_MIN; // RULE19
         hi = sgn ? rgdec_pkg::S_MAX : rgdec_pkg::U_MAX; // RULE19
         if (sum < lo)
         begin
            sum = lo; // RULE4 RULE13
         end
         else if (sum > hi)
         begin
            sum = hi; // RULE4 RULE13
         end
         decode_texel = sum[rgdec_pkg::RES_W-1:0]; // RULE15
      end
   endfunction : decode_texel

   // ************************************************************
   // widening to the filter width
   // ************************************************************

   // replicating a negative value directly would bias it toward zero, so the
   // signed path works on the magnitude and restores the sign afterwards
   function automatic logic [rgdec_pkg::WIDE_W-1:0] widen(
      input logic [rgdec_pkg::RES_W-1:0] v,
      input logic                        sgn
   );
      logic [rgdec_pkg::RES_W-1:0]  mag;
      logic [rgdec_pkg::WIDE_W-1:0] ext;
      logic [rgdec_pkg::WIDE_W-1:0] w;
      begin
         if (!sgn)
         begin
            ext   = {{(rgdec_pkg::WIDE_W-rgdec_pkg::RES_W){1'b0}}, v};
            widen = (ext << rgdec_pkg::WIDEN_SH_L) + (ext >> rgdec_pkg::U_WIDEN_SH_R); // RULE5
         end
         else
         begin
            mag = v[rgdec_pkg::RES_W-1] ? (~v + 11'h001) : v; // RULE17
            ext = {{(rgdec_pkg::WIDE_W-rgdec_pkg::RES_W){1'b0}}, mag};
            // sign bit of mag is zero, so it is never replicated
            w   = (ext << rgdec_pkg::WIDEN_SH_L) + (ext >> rgdec_pkg::S_WIDEN_SH_R); // RULE16
            widen = v[rgdec_pkg::RES_W-1] ? (~w + 16'h0001) : w; // RULE17
         end
      end
   endfunction : widen

   // ************************************************************
   // block assembly
   // ************************************************************
   logic [rgdec_pkg::WORD_W-1:0] red_block_word;
   logic [rgdec_pkg::WORD_W-1:0] green_block_word;
   logic                         signed_mode;
   logic                         dual_mode;

   // byte 0 of the bus is the lowest address; it lands in the top of the word
   always_comb
   begin
      red_block_word   = '0;
      green_block_word = '0;
      for (int b = 0; b < rgdec_pkg::WORD_BYTES; b++)
      begin
         red_block_word[(rgdec_pkg::WORD_BYTES-1-b)*rgdec_pkg::BYTE_W +: rgdec_pkg::BYTE_W] =
            blk_data_i[rgdec_pkg::BLOCK_W-1-b*rgdec_pkg::BYTE_W -: rgdec_pkg::BYTE_W]; // RULE1 RULE2 RULE6
         green_block_word[(rgdec_pkg::WORD_BYTES-1-b)*rgdec_pkg::BYTE_W +: rgdec_pkg::BYTE_W] =
            blk_data_i[rgdec_pkg::WORD_W-1-b*rgdec_pkg::BYTE_W -: rgdec_pkg::BYTE_W]; // RULE1 RULE2
      end
   end

   // mode decode; an unknown code falls back to single unsigned
   always_comb
   begin
      signed_mode = 1'b0;
      dual_mode   = 1'b0;
      case (fmt_i)
         rgdec_pkg::RGDEC_SINGLE_CHANNEL_SIGNED_FORMAT:
         begin
            signed_mode = 1'b1; // RULE19
         end
         rgdec_pkg::RGDEC_DUAL_CHANNEL_UNSIGNED_FORMAT:
         begin
            dual_mode = 1'b1;
         end
         default:
         begin
            signed_mode = 1'b0;
         end
      endcase
   end

   // ************************************************************
   // state
   // ************************************************************
   rgdec_pkg::rgdec_state_t state;
   rgdec_pkg::rgdec_state_t next_state;
   logic [rgdec_pkg::RES_W-1:0] red11;
   logic [rgdec_pkg::RES_W-1:0] green11;

   // one shared decode per channel; green is the same procedure on its own word
   always_comb
   begin
      red11   = decode_texel(red_block_word, texel_i, signed_mode); // RULE3
      green11 = dual_mode ? decode_texel(green_block_word, texel_i, 1'b0) : '0; // RULE3
   end

   // a taken block loads the outputs; otherwise results hold, valid drops
   always_comb
   begin
      next_state       = state;
      next_state.valid = blk_valid_i;
      if (blk_valid_i)
      begin
         next_state.fmt       = signed_mode ? rgdec_pkg::RGDEC_SINGLE_CHANNEL_SIGNED_FORMAT :
                                dual_mode   ? rgdec_pkg::RGDEC_DUAL_CHANNEL_UNSIGNED_FORMAT :
                                              rgdec_pkg::RGDEC_SINGLE_CHANNEL_UNSIGNED_FORMAT;
         next_state.red.v11   = red11; // RULE18
         next_state.red.v16   = widen(red11, signed_mode); // RULE18
         next_state.green.v11 = green11;
         next_state.green.v16 = widen(green11, 1'b0); // RULE18
      end
   end

   // clock enable low freezes everything, valid included
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state.valid <= 1'b0;
         state.fmt   <= rgdec_pkg::RGDEC_SINGLE_CHANNEL_UNSIGNED_FORMAT;
         state.red   <= '0;
         state.green <= '0;
      end
      else if (en_i)
      begin
         state <= next_state;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign valid_o = state.valid;
   assign fmt_o   = state.fmt;
   assign red_o   = state.red;
   assign green_o = state.green;

endmodule : rgdec_decoder

`default_nettype wire

// File: tb/rgdec_props.sv
`default_nettype none

// ************************************************************
// port-level checks of the block decoder
// ************************************************************
module rgdec_props (
   input wire logic                    clk_i,
   input wire logic                    rst_n_i,
   input wire logic                    en_i,
   input wire logic                    blk_valid_i,
   input wire logic [127:0]            blk_data_i,
   input wire rgdec_pkg::rgdec_fmt_t   fmt_i,
   input wire logic [3:0]              texel_i,
   input wire logic                    valid_o,
   input wire rgdec_pkg::rgdec_fmt_t   fmt_o,
   input wire rgdec_pkg::rgdec_texel_t red_o,
   input wire rgdec_pkg::rgdec_texel_t green_o
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam rgdec_pkg::rgdec_fmt_t DU = rgdec_pkg::RGDEC_DUAL_CHANNEL_UNSIGNED_FORMAT;
   localparam rgdec_pkg::rgdec_fmt_t SS = rgdec_pkg::RGDEC_SINGLE_CHANNEL_SIGNED_FORMAT;
   logic [10:0] neg_v;

   // magnitude of a negative result; -1024 never occurs, so no overflow here
   assign neg_v = 11'h000 - red_o.v11;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   AST_TAKE: assert property (en_i && blk_valid_i |=> valid_o && fmt_o == $past(fmt_i))
      else $error("taken request gave no result");
   AST_IDLE: assert property (en_i && !blk_valid_i |=> !valid_o && $stable(red_o))
      else $error("idle cycle changed the result");
   AST_FREEZE: assert property (!en_i |=> $stable(valid_o) && $stable(green_o))
      else $error("disabled cycle changed state");
   AST_GREEN_OFF: assert property (valid_o && fmt_o != DU |-> green_o == '0)
      else $error("green nonzero for single channel");
   AST_U_WIDEN_RED: assert property (valid_o && fmt_o != SS
      |-> red_o.v16 == {red_o.v11, 5'h00} + 16'(red_o.v11 >> 6))
      else $error("unsigned red widening wrong");
   AST_U_WIDEN_GREEN: assert property (valid_o && fmt_o == DU
      |-> green_o.v16 == {green_o.v11, 5'h00} + 16'(green_o.v11 >> 6))
      else $error("unsigned green widening wrong");
   AST_S_SAT: assert property (valid_o && fmt_o == SS |-> red_o.v11 != 11'h400)
      else $error("signed result below saturation");
   AST_S_POS: assert property (valid_o && fmt_o == SS && !red_o.v11[10]
      |-> red_o.v16 == {red_o.v11, 5'h00} + 16'(red_o.v11 >> 5))
      else $error("positive signed widening wrong");
   AST_S_NEG: assert property (valid_o && fmt_o == SS && red_o.v11[10]
      |-> red_o.v16 == 16'h0000 - ({neg_v, 5'h00} + 16'(neg_v >> 5)))
      else $error("negative signed widening wrong");

   C_DUAL: cover property (valid_o && fmt_o == DU);
   C_NEG: cover property (valid_o && fmt_o == SS && red_o.v11[10]);
   C_FREEZE: cover property (!en_i && valid_o);
endmodule : rgdec_props

bind rgdec_decoder rgdec_props rgdec_props_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en_i),
   .blk_valid_i(blk_valid_i), .blk_data_i(blk_data_i), .fmt_i(fmt_i), .texel_i(texel_i),
   .valid_o(valid_o), .fmt_o(fmt_o), .red_o(red_o), .green_o(green_o));

`default_nettype wire

// File: tb/rgdec_mem_model.sv
`default_nettype none

// ************************************************************
// texture memory: sixteen blocks of sixteen bytes
// ************************************************************
module rgdec_mem_model (
   input wire logic [3:0] addr_i,
   output logic [127:0]   blk_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [0:255];

   // lowest address lands in the top byte, so word order follows memory order
   always_comb
   begin
      for (int i = 0; i < 16; i++)
      begin
         blk_o[127-8*i -: 8] = mem[{addr_i, 4'h0} + i];
      end
   end
endmodule : rgdec_mem_model

`default_nettype wire

// File: tb/rgdec_decoder_tb_top.sv
`default_nettype none

module rgdec_decoder_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef rgdec_pkg::rgdec_texel_t rgdec_tx_t;
   logic                  clk_i = 1'b0;
   logic                  rst_n_i = 1'b0;
   logic                  en_i = 1'b0;
   logic                  blk_valid_i = 1'b0;
   logic [3:0]            addr = 4'h0;
   logic [3:0]            texel_i = 4'h0;
   rgdec_pkg::rgdec_fmt_t fmt_i = rgdec_pkg::RGDEC_SINGLE_CHANNEL_UNSIGNED_FORMAT;
   logic [127:0]          blk_data;
   logic                  valid_o, m_valid;
   rgdec_pkg::rgdec_fmt_t fmt_o, m_fmt;
   rgdec_tx_t             red_o, green_o, m_red, m_green;
   int                    n_mismatch = 0, checked = 0, cyc = 0, seed = 67106;
   int                    tab[8] = '{-1, -2, -3, -10, 0, 1, 2, 9};
   rgdec_pkg::rgdec_fmt_t fmts[3] = '{rgdec_pkg::RGDEC_SINGLE_CHANNEL_UNSIGNED_FORMAT,
      rgdec_pkg::RGDEC_DUAL_CHANNEL_UNSIGNED_FORMAT, rgdec_pkg::RGDEC_SINGLE_CHANNEL_SIGNED_FORMAT};

   always #50 clk_i = ~clk_i;

   rgdec_mem_model rgdec_mem_model_inst (.addr_i(addr), .blk_o(blk_data));
   rgdec_decoder rgdec_decoder_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en_i),
      .blk_valid_i(blk_valid_i), .blk_data_i(blk_data), .fmt_i(fmt_i), .texel_i(texel_i),
      .valid_o(valid_o), .fmt_o(fmt_o), .red_o(red_o), .green_o(green_o));

   // reference decode of one channel word, plain integer arithmetic
   function automatic rgdec_tx_t dec(input logic [63:0] w, input int t, input bit sg);
      int b, m, s, x;
      b = sg ? ((w[63:56] == 8'h80) ? -127 : int'($signed(w[63:56]))) : int'(w[63:56]);
      m = int'(w[55:52]);
      s = b * 8 + (sg ? 0 : 4) + ((m != 0) ? tab[w[47-3*t -: 3]] * m * 8 : tab[w[47-3*t -: 3]]);
      s = sg ? ((s > 1023) ? 1023 : ((s < -1023) ? -1023 : s)) : ((s > 2047) ? 2047 : ((s < 0) ? 0 : s));
      x = (s < 0) ? -s : s;
      x = sg ? (x << 5) + (x >> 5) : (x << 5) + (x >> 6);
      x = (s < 0) ? -x : x;
      dec.v11 = s[10:0];
      dec.v16 = x[15:0];
   endfunction : dec

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp)
      begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         n_mismatch++;
      end
   endtask : chk

   task automatic complete_run;
      $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : complete_run

   task automatic put(input int n, input logic [127:0] d);
      for (int i = 0; i < 16; i++)
      begin
         rgdec_mem_model_inst.mem[n*16+i] = d[127-8*i -: 8];
      end
   endtask : put

   // compare settled outputs, then drive the next cycle and advance the model
   task automatic step(input bit en, input bit v, input logic [3:0] a, t, input int f);
      chk(valid_o, m_valid);
      chk(fmt_o, m_fmt);
      chk(red_o, m_red);
      chk(green_o, m_green);
      en_i = en;
      blk_valid_i = v;
      addr = a;
      texel_i = t;
      fmt_i = fmts[f];
      #1;
      if (en)
      begin
         m_valid = v;
         if (v)
         begin
            m_fmt = fmts[f];
            m_red = dec(blk_data[127:64], t, f == 2);
            m_green = (f == 1) ? dec(blk_data[63:0], t, 1'b0) : '0;
         end
      end
      @(negedge clk_i);
   endtask : step

   task automatic do_reset(input int n);
      rst_n_i = 1'b0;
      m_valid = 1'b0;
      m_fmt = fmts[0];
      m_red = '0;
      m_green = '0;
      repeat (n) @(negedge clk_i);
      rst_n_i = 1'b1;
   endtask : do_reset

   // cut a hang short well beyond the planned run length
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_mismatch++;
         complete_run();
      end
   end

   initial
   begin
      for (int i = 0; i < 256; i++) rgdec_mem_model_inst.mem[i] = 8'($random(seed));
      put(0, {8'h67, 4'h2, 4'hD, {16{3'b011}}, 8'h3C, 4'h0, 4'hD, {16{3'b011}}});
      put(1, {8'h80, 4'hF, 4'hD, {16{3'b011}}, 8'h7F, 4'hF, 4'hD, {16{3'b111}}});
      put(2, {8'h3C, 4'h2, 4'hD, {16{3'b011}}, 8'hFF, 4'h0, 4'hD, {16{3'b000}}});
      put(3, {8'h00, 4'hF, 4'hD, {16{3'b011}}, 8'hFF, 4'hF, 4'hD, {16{3'b111}}});
      chk(dec({8'h67, 4'h2, 4'hD, {16{3'b011}}}, 1, 1'b0), {11'd668, 16'd21386});
      chk(dec({8'h3C, 4'h0, 4'hD, {16{3'b011}}}, 1, 1'b1), {11'd470, 16'd15054});
      @(negedge clk_i);
      do_reset(4);
      // edge cases back to back in every format
      for (int b = 0; b < 4; b++)
         for (int f = 0; f < 3; f++) step(1'b1, 1'b1, 4'(b), 4'($random(seed)), f);
      for (int k = 0; k < 600; k++)
      begin
         if (k == 300) do_reset(2);
         step($random(seed) % 8 != 0, $random(seed) % 4 != 0, 4'($random(seed)),
            4'($random(seed)), ($random(seed) & 32'h7FFFFFFF) % 3);
      end
      step(1'b0, 1'b0, 4'h0, 4'h0, 0);
      complete_run();
   end
endmodule : rgdec_decoder_tb_top

`default_nettype wire
